// ---- pkg/cds_pkg.sv ----
// Package with constants for the chain diagnostics and status indicator block.
package cds_pkg;
   localparam int CLK_HZ = 200_000_000;
   // Diagnostics byte layout and access.
   localparam logic [7:0] NODE_GATEWAY = 8'h00;
   localparam int BIT_IF_FAULT = 0;
   localparam int BIT_INIT_ERR = 4;
   localparam int BIT_TEACH_ERR = 5;
   localparam int BIT_SHORT = 6;
   localparam int BIT_COMM_ERR = 7;
   localparam logic [7:0] DIAG_RESET = 8'h00;
   // Host commands.
   localparam logic [7:0] CMD_CATEGORY = 8'h02;
   localparam logic [7:0] CMD_TEACH = 8'h63;
   localparam logic [7:0] ADDR_SLAVE_MIN = 8'h01;
   localparam logic [7:0] ADDR_SLAVE_MAX = 8'h1F;
   localparam logic [7:0] TEACH_DONE_DATA = 8'h00;
   localparam logic [7:0] RESP_INVALID = 8'hFF;
   localparam int SLAVES = 31;
   // Times in milliseconds and the derived counts of millisecond ticks.
   localparam int FAULT_DELAY_MS = 1000;
   localparam int HOLD_MS = 2000;
   localparam int READY_MS = 30000;
   localparam int FLASH_PERIOD_MS = 1000;
   localparam int SHORT_FLASH_MS = 200;
   localparam int LONG_FLASH_MS = 600;
   localparam int DEBOUNCE_MS = 20;
   localparam int TICK_CYCLES = CLK_HZ / 1000;
   localparam logic [15:0] FAULT_DELAY_TICKS = 16'(FAULT_DELAY_MS);
   localparam logic [15:0] HOLD_TICKS = 16'(HOLD_MS);
   localparam logic [15:0] READY_TICKS = 16'(READY_MS);
   localparam logic [15:0] FLASH_TICKS = 16'(FLASH_PERIOD_MS);
   localparam logic [15:0] SHORT_TICKS = 16'(SHORT_FLASH_MS);
   localparam logic [15:0] LONG_TICKS = 16'(LONG_FLASH_MS);
   localparam logic [15:0] DEBOUNCE_TICKS = 16'(DEBOUNCE_MS);
   // Lamp colour codes: bit 1 red, bit 0 yellow or green.
   localparam logic [1:0] LAMP_OFF = 2'h0;
   localparam logic [1:0] LAMP_YEL = 2'h1;
   localparam logic [1:0] LAMP_RED = 2'h2;
   typedef enum logic [1:0] {
      CDS_BOOT = 2'b00,
      CDS_RUN = 2'b01,
      CDS_TEACH = 2'b10
   } cds_state_e;
endpackage

// ---- hdl/cds_cfg_mem.sv ----
// Small memory holding the saved setpoint chain configuration.
`timescale 1ns/1ps
`default_nettype none
module cds_cfg_mem #(
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [DEPTH];

   // No reset on the array keeps it a plain RAM; a valid flag outside guards it.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// ---- hdl/cds_top.sv ----
// Chain diagnostics byte, status lamps, teach-in trigger and configuration compare.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Diagnostics byte is the response byte of node address zero.
// - Bit 0 is the interface fault, raised after one second, data invalid.
// - Bit 4 is the chain initialisation error needing a power cycle.
// - Bit 5 flags chain differs from saved setup; cleared by successful teach.
// - Bit 6 flags a short circuit on the chain cabling.
// - Bit 7 flags an unreachable slave; slave data then invalid.
// - Power lamp steady green when supplied and ready, else off.
// - Function lamp flashes yellow on teach needed, steady yellow without chain.
// - Fault lamp flashes yellow while teach-in runs.
// - Fault lamp flashes yellow on poor quality, red on short circuit.
// - Fault lamp steady red while actual and setpoint setups mismatch.
// - Fault causes are told apart by short and long flash patterns.
// - Teach starts after a two second button hold or a web request.
// - Successful teach stores discovered chain and turns fault lamp off.
// - Ready about thirty seconds after power-up; lamps show start-up.
// - Teach is required with no saved setup or a changed chain.
// - Command 0x02 with slave address 1 to 31 reads its category.
// - Command 0x63 to address zero triggers a chain teach-in.
module cds_top #(
   parameter int TICK_CYCLES = cds_pkg::TICK_CYCLES,
   parameter logic [15:0] FAULT_DELAY_TICKS = cds_pkg::FAULT_DELAY_TICKS,
   parameter logic [15:0] HOLD_TICKS = cds_pkg::HOLD_TICKS,
   parameter logic [15:0] READY_TICKS = cds_pkg::READY_TICKS,
   parameter logic [15:0] FLASH_TICKS = cds_pkg::FLASH_TICKS,
   parameter logic [15:0] SHORT_TICKS = cds_pkg::SHORT_TICKS,
   parameter logic [15:0] LONG_TICKS = cds_pkg::LONG_TICKS,
   parameter logic [15:0] DEBOUNCE_TICKS = cds_pkg::DEBOUNCE_TICKS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic supply_ok,
   input wire logic teach_button_n,
   input wire logic web_teach_req,
   input wire logic chain_present,
   input wire logic chain_if_fault,
   input wire logic chain_init_err,
   input wire logic chain_short,
   input wire logic chain_comm_err,
   input wire logic chain_quality_poor,
   input wire logic disc_valid,
   input wire logic [4:0] disc_addr,
   input wire logic [7:0] disc_category,
   input wire logic [4:0] disc_count,
   input wire logic disc_scan_done,
   input wire logic host_req,
   input wire logic [7:0] host_cmd,
   input wire logic [7:0] host_addr,
   output logic host_ack,
   output logic [7:0] host_data,
   output logic [7:0] diag_gateway,
   output logic power_lamp_green,
   output logic function_lamp_yellow,
   output logic fault_lamp_yellow,
   output logic fault_lamp_red,
   output logic teach_active,
   output logic chain_data_valid
);
   logic rst_s1, rst_n;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Millisecond tick; all slow timers count it.
   logic [31:0] pre_reg;
   logic tick;
   assign tick = (pre_reg == 32'(TICK_CYCLES - 1));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) pre_reg <= 32'h0000_0000;
      else if (tick) pre_reg <= 32'h0000_0000;
      else pre_reg <= pre_reg + 32'h0000_0001;
   end

   // Pin inputs pass three flops; a change counts when stages two and three agree.
   logic [2:0] btn_sy, sup_sy, web_sy;
   logic btn_lvl, sup_lvl, web_lvl;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         btn_sy <= 3'h0;
         sup_sy <= 3'h0;
         web_sy <= 3'h0;
         btn_lvl <= 1'b0;
         sup_lvl <= 1'b0;
         web_lvl <= 1'b0;
      end else begin
         btn_sy <= {btn_sy[1:0], ~teach_button_n};
         sup_sy <= {sup_sy[1:0], supply_ok};
         web_sy <= {web_sy[1:0], web_teach_req};
         if (btn_sy[1] == btn_sy[2]) btn_lvl <= btn_sy[2];
         if (sup_sy[1] == sup_sy[2]) sup_lvl <= sup_sy[2];
         if (web_sy[1] == web_sy[2]) web_lvl <= web_sy[2];
      end
   end

   logic [15:0] deb_reg;
   logic btn_db_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         deb_reg <= 16'h0000;
         btn_db_reg <= 1'b0;
      end else if (btn_lvl == btn_db_reg) begin
         deb_reg <= 16'h0000;
      end else if (tick) begin
         if (deb_reg >= DEBOUNCE_TICKS - 16'h0001) begin
            btn_db_reg <= btn_lvl;
            deb_reg <= 16'h0000;
         end else begin
            deb_reg <= deb_reg + 16'h0001;
         end
      end
   end

   // two second hold, one trigger per press
   logic [15:0] hold_reg;
   logic hold_fired_reg, btn_teach;
   assign btn_teach = btn_db_reg && tick && !hold_fired_reg
      && (hold_reg >= HOLD_TICKS - 16'h0001);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_reg <= 16'h0000;
         hold_fired_reg <= 1'b0;
      end else if (!btn_db_reg) begin
         hold_reg <= 16'h0000;
         hold_fired_reg <= 1'b0;
      end else if (tick) begin
         if (btn_teach) hold_fired_reg <= 1'b1;
         else if (!hold_fired_reg) hold_reg <= hold_reg + 16'h0001;
      end
   end

   logic web_prev_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) web_prev_reg <= 1'b0;
      else web_prev_reg <= web_lvl;
   end

   logic host_teach;
   assign host_teach = host_req && host_cmd == cds_pkg::CMD_TEACH
      && host_addr == cds_pkg::NODE_GATEWAY;

   logic teach_req;
   assign teach_req = btn_teach || (web_lvl && !web_prev_reg) || host_teach;

   logic [15:0] boot_reg;
   logic ready;
   cds_pkg::cds_state_e state_reg;
   assign ready = state_reg != cds_pkg::CDS_BOOT;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) boot_reg <= 16'h0000;
      else if (tick && boot_reg != READY_TICKS) boot_reg <= boot_reg + 16'h0001;
   end

   // Teach captures the scan into the memory; the scan owner drives disc_*.
   logic saved_valid_reg;
   logic [4:0] saved_count_reg;
   logic [4:0] cmp_addr;
   logic [7:0] mem_rdata;
   logic mem_we;
   logic mismatch_reg;
   logic teach_ok;
   assign mem_we = state_reg == cds_pkg::CDS_TEACH && disc_valid;
   assign teach_ok = state_reg == cds_pkg::CDS_TEACH && disc_scan_done
      && disc_count != 5'h00;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= cds_pkg::CDS_BOOT;
      end else begin
         case (state_reg)
            cds_pkg::CDS_BOOT: if (boot_reg == READY_TICKS) state_reg <= cds_pkg::CDS_RUN;
            cds_pkg::CDS_RUN: if (teach_req && chain_present) state_reg <= cds_pkg::CDS_TEACH;
            cds_pkg::CDS_TEACH: if (disc_scan_done) state_reg <= cds_pkg::CDS_RUN;
            default: state_reg <= cds_pkg::CDS_BOOT;
         endcase
      end
   end
   assign teach_active = state_reg == cds_pkg::CDS_TEACH;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         saved_valid_reg <= 1'b0;
         saved_count_reg <= 5'h00;
      end else if (teach_ok) begin
         saved_valid_reg <= 1'b1;
         saved_count_reg <= disc_count;
      end
   end

   // category read shares the read port with the compare.
   logic cat_req, cat_pend_reg;
   assign cat_req = host_req && host_cmd == cds_pkg::CMD_CATEGORY
      && host_addr >= cds_pkg::ADDR_SLAVE_MIN && host_addr <= cds_pkg::ADDR_SLAVE_MAX;
   assign cmp_addr = cat_req ? host_addr[4:0] : disc_addr;

   cds_cfg_mem #(.DEPTH(32), .AW(5)) u_mem (
      .clk(clk),
      .we(mem_we),
      .waddr(disc_addr),
      .wdata(disc_category),
      .raddr(cmp_addr),
      .rdata(mem_rdata)
   );

   // compare discovered slaves against the setpoint
   logic cmp_pend_reg;
   logic [7:0] cmp_cat_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_pend_reg <= 1'b0;
         cmp_cat_reg <= 8'h00;
         mismatch_reg <= 1'b0;
      end else begin
         cmp_pend_reg <= disc_valid && state_reg == cds_pkg::CDS_RUN && !cat_req;
         cmp_cat_reg <= disc_category;
         if (teach_ok) begin
            mismatch_reg <= 1'b0;
         end else if (state_reg == cds_pkg::CDS_RUN) begin
            if (cmp_pend_reg && saved_valid_reg && mem_rdata != cmp_cat_reg) begin
               mismatch_reg <= 1'b1;
            end else if (disc_scan_done && saved_valid_reg
                  && disc_count != saved_count_reg) begin
               mismatch_reg <= 1'b1;
            end
         end
      end
   end
   logic teach_needed;
   assign teach_needed = !saved_valid_reg || mismatch_reg;

   // one second persistence of interface fault
   logic [15:0] flt_reg;
   logic if_fault_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flt_reg <= 16'h0000;
         if_fault_reg <= 1'b0;
      end else if (!chain_if_fault) begin
         flt_reg <= 16'h0000;
         if_fault_reg <= 1'b0;
      end else if (tick) begin
         if (flt_reg >= FAULT_DELAY_TICKS - 16'h0001) if_fault_reg <= 1'b1;
         else flt_reg <= flt_reg + 16'h0001;
      end
   end

   // diagnostics byte, bits 1 to 3 zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         diag_gateway <= cds_pkg::DIAG_RESET;
      end else begin
         diag_gateway <= cds_pkg::DIAG_RESET;
         diag_gateway[cds_pkg::BIT_IF_FAULT] <= if_fault_reg;
         diag_gateway[cds_pkg::BIT_INIT_ERR] <= chain_init_err;
         diag_gateway[cds_pkg::BIT_TEACH_ERR] <= mismatch_reg && !teach_ok;
         diag_gateway[cds_pkg::BIT_SHORT] <= chain_short;
         diag_gateway[cds_pkg::BIT_COMM_ERR] <= chain_comm_err;
      end
   end
   // slave data validity follows bits 0 and 7
   assign chain_data_valid = !diag_gateway[cds_pkg::BIT_IF_FAULT]
      && !diag_gateway[cds_pkg::BIT_COMM_ERR];

   // Host answers: teach done next cycle, category after the memory read.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cat_pend_reg <= 1'b0;
         host_ack <= 1'b0;
         host_data <= 8'h00;
      end else begin
         cat_pend_reg <= cat_req;
         host_ack <= 1'b0;
         if (cat_pend_reg) begin
            host_ack <= 1'b1;
            host_data <= saved_valid_reg ? mem_rdata : cds_pkg::RESP_INVALID;
         end else if (host_teach) begin
            host_ack <= 1'b1;
            host_data <= cds_pkg::TEACH_DONE_DATA;
         end else if (host_req && !cat_req) begin
            host_ack <= 1'b1;
            host_data <= host_addr == cds_pkg::NODE_GATEWAY ? diag_gateway
               : cds_pkg::RESP_INVALID;
         end
      end
   end

   // flash timing: slow flash, short and long pulse shapes
   logic [15:0] fl_reg;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) fl_reg <= 16'h0000;
      else if (tick) fl_reg <= (fl_reg >= FLASH_TICKS - 16'h0001) ? 16'h0000
         : fl_reg + 16'h0001;
   end
   logic ph_short, ph_long;
   assign ph_short = fl_reg < SHORT_TICKS;
   assign ph_long = fl_reg < LONG_TICKS;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) power_lamp_green <= 1'b0;
      else power_lamp_green <= sup_lvl && ready;
   end

   // function lamp; during start-up it flashes to show progress
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) function_lamp_yellow <= 1'b0;
      else if (!ready) function_lamp_yellow <= ph_long;
      else if (!chain_present) function_lamp_yellow <= 1'b1;
      else function_lamp_yellow <= teach_needed && ph_long;
   end

   // Fault lamp priority: short, teach running, mismatch, poor quality.
   logic [1:0] fault_col;
   always_comb begin
      fault_col = cds_pkg::LAMP_OFF;
      // short circuit flashes red in short pulses
      if (chain_short) fault_col = ph_short ? cds_pkg::LAMP_RED : cds_pkg::LAMP_OFF;
      // teach running flashes yellow in long pulses
      else if (teach_active) fault_col = ph_long ? cds_pkg::LAMP_YEL : cds_pkg::LAMP_OFF;
      else if (mismatch_reg) fault_col = cds_pkg::LAMP_RED;
      // poor quality flashes yellow in short pulses
      else if (chain_quality_poor)
         fault_col = ph_short ? cds_pkg::LAMP_YEL : cds_pkg::LAMP_OFF;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_lamp_yellow <= 1'b0;
         fault_lamp_red <= 1'b0;
      end else begin
         fault_lamp_yellow <= fault_col[0];
         fault_lamp_red <= fault_col[1];
      end
   end

   a_fault_delay: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(if_fault_reg) |-> flt_reg >= FAULT_DELAY_TICKS - 16'h0001)
      else $error("interface fault raised before its delay");
   a_zero_bits: assert property (@(posedge clk) disable iff (!rst_n)
      diag_gateway[3:1] == 3'h0)
      else $error("unused diagnostics bits not zero");
   a_short_bit: assert property (@(posedge clk) disable iff (!rst_n)
      chain_short |=> diag_gateway[cds_pkg::BIT_SHORT])
      else $error("short bit did not follow the short input");
   a_comm_bit: assert property (@(posedge clk) disable iff (!rst_n)
      chain_comm_err |=> !chain_data_valid)
      else $error("data valid while a slave is unreachable");
   a_init_bit: assert property (@(posedge clk) disable iff (!rst_n)
      chain_init_err |=> diag_gateway[cds_pkg::BIT_INIT_ERR])
      else $error("init error bit missing");
   a_teach_clears: assert property (@(posedge clk) disable iff (!rst_n)
      teach_ok |=> !mismatch_reg ##1 !diag_gateway[cds_pkg::BIT_TEACH_ERR])
      else $error("teach error not cleared by teach");
   a_power_lamp: assert property (@(posedge clk) disable iff (!rst_n)
      !sup_lvl |=> !power_lamp_green)
      else $error("power lamp lit without supply");
   a_no_chain: assert property (@(posedge clk) disable iff (!rst_n)
      ready && !chain_present |=> function_lamp_yellow)
      else $error("function lamp not steady without chain");
   a_mismatch_red: assert property (@(posedge clk) disable iff (!rst_n)
      mismatch_reg && !chain_short && !teach_active |=> fault_lamp_red)
      else $error("fault lamp not red on mismatch");
   a_teach_cmd: assert property (@(posedge clk) disable iff (!rst_n)
      host_teach && state_reg == cds_pkg::CDS_RUN && chain_present
         |=> teach_active && host_ack)
      else $error("teach command did not start teach");
   a_hold_time: assert property (@(posedge clk) disable iff (!rst_n)
      btn_teach |-> btn_db_reg && hold_reg == HOLD_TICKS - 16'h0001)
      else $error("button teach before the hold time");
endmodule
`default_nettype wire

// ---- dv/cds_chain_model.sv ----
// Behavioural model of the slave chain as seen by the discovery inputs.
`timescale 1ns/1ps
`default_nettype none
module cds_chain_model (
   input wire logic clk,
   output logic disc_valid,
   output logic [4:0] disc_addr,
   output logic [7:0] disc_category,
   output logic [4:0] disc_count,
   output logic disc_scan_done
);
   logic [7:0] cat_mem [1:31];
   initial begin
      disc_valid = 1'b0;
      disc_addr = 5'h00;
      disc_category = 8'h00;
      disc_count = 5'h00;
      disc_scan_done = 1'b0;
   end
   // Slaves are reported one at a time, with gap plus one idle cycles between them.
   // Idle lines carry inverted junk so that stale values cannot be mistaken for data.
   task automatic scan(input int n, input int gap);
      for (int i = 1; i <= n; i++) begin
         @(negedge clk);
         disc_valid = 1'b1;
         disc_addr = 5'(i);
         disc_category = cat_mem[i];
         @(negedge clk);
         disc_valid = 1'b0;
         disc_addr = ~disc_addr;
         disc_category = ~disc_category;
         repeat (gap) @(negedge clk);
      end
      @(negedge clk);
      disc_scan_done = 1'b1;
      disc_count = 5'(n);
      @(negedge clk);
      disc_scan_done = 1'b0;
      disc_count = ~disc_count;
   endtask
endmodule
`default_nettype wire

// ---- dv/chain_diag_status_indicator_tb_top.sv ----
// Self-checking bench for the diagnostics byte, status lamps and teach-in control.
`timescale 1ns/1ps
`default_nettype none
module chain_diag_status_indicator_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic supply_ok = 1'b1;
   logic teach_button_n = 1'b1;
   logic web_teach_req = 1'b0;
   logic chain_present = 1'b1;
   logic chain_if_fault = 1'b0;
   logic [2:0] errs = 3'h0;
   logic chain_quality_poor = 1'b0;
   logic host_req = 1'b0;
   logic [7:0] host_cmd = 8'h00;
   logic [7:0] host_addr = 8'h00;
   logic disc_valid, disc_scan_done, host_ack, teach_active, chain_data_valid;
   logic power_lamp_green, function_lamp_yellow, fault_lamp_yellow, fault_lamp_red;
   logic [4:0] disc_addr, disc_count;
   logic [7:0] disc_category, host_data, diag_gateway;
   logic [7:0] exp_q [$];
   logic [7:0] cats [1:3];
   int errors = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 81386;
   int highs, lows;
   always #2.5 clk = ~clk;
   // Short tick counts keep the whole run to about a thousand cycles.
   localparam int TB_TICK = 4;
   localparam logic [15:0] TB_FAULT = 16'h0005;
   localparam logic [15:0] TB_HOLD = 16'h0005;
   localparam logic [15:0] TB_READY = 16'h000A;
   localparam logic [15:0] TB_FLASH = 16'h0008;
   localparam logic [15:0] TB_SHORT = 16'h0002;
   localparam logic [15:0] TB_LONG = 16'h0005;
   localparam logic [15:0] TB_DEB = 16'h0002;
   cds_top #(.TICK_CYCLES(TB_TICK), .FAULT_DELAY_TICKS(TB_FAULT), .HOLD_TICKS(TB_HOLD),
      .READY_TICKS(TB_READY), .FLASH_TICKS(TB_FLASH), .SHORT_TICKS(TB_SHORT),
      .LONG_TICKS(TB_LONG), .DEBOUNCE_TICKS(TB_DEB)) i_cds_top (.clk(clk), .rstn(rstn),
      .supply_ok(supply_ok), .teach_button_n(teach_button_n), .web_teach_req(web_teach_req),
      .chain_present(chain_present), .chain_if_fault(chain_if_fault),
      .chain_init_err(errs[0]), .chain_short(errs[1]), .chain_comm_err(errs[2]),
      .chain_quality_poor(chain_quality_poor), .disc_valid(disc_valid),
      .disc_addr(disc_addr), .disc_category(disc_category), .disc_count(disc_count),
      .disc_scan_done(disc_scan_done), .host_req(host_req), .host_cmd(host_cmd),
      .host_addr(host_addr), .host_ack(host_ack), .host_data(host_data),
      .diag_gateway(diag_gateway), .power_lamp_green(power_lamp_green),
      .function_lamp_yellow(function_lamp_yellow), .fault_lamp_yellow(fault_lamp_yellow),
      .fault_lamp_red(fault_lamp_red), .teach_active(teach_active),
      .chain_data_valid(chain_data_valid));
   cds_chain_model i_cds_chain_model (.clk(clk), .disc_valid(disc_valid),
      .disc_addr(disc_addr), .disc_category(disc_category), .disc_count(disc_count),
      .disc_scan_done(disc_scan_done));
   task automatic test_done;
      if (errors == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         errors++;
      end
   endtask
   function automatic logic lamp(input int sel);
      case (sel)
         0: return power_lamp_green;
         1: return function_lamp_yellow;
         2: return fault_lamp_yellow;
         default: return fault_lamp_red;
      endcase
   endfunction
   // Mode 0 steady off, 1 steady on, 2 flashing within a window of two and a half flash periods.
   task automatic lamp_is(input string name, input int sel, input int mode);
      highs = 0;
      lows = 0;
      repeat (80) begin
         @(negedge clk);
         if (lamp(sel) === 1'b1) highs++;
         if (lamp(sel) === 1'b0) lows++;
      end
      if (mode == 2) check(name, 8'h01, 8'(highs > 0 && lows > 0 && highs + lows == 80));
      else check(name, 8'h50, 8'(mode == 1 ? highs : lows));
   endtask
   task automatic host(input logic [7:0] cmd, input logic [7:0] addr, input logic [7:0] exp);
      @(negedge clk);
      exp_q.push_back(exp);
      host_req = 1'b1;
      host_cmd = cmd;
      host_addr = addr;
      @(negedge clk);
      host_req = 1'b0;
      host_cmd = ~cmd;
      host_addr = ~addr;
      repeat (4) @(negedge clk);
      check("host_unanswered", 8'h00, 8'(exp_q.size()));
   endtask
   task automatic wait_teach(input logic lvl, input int lim);
      int k;
      k = 0;
      while (teach_active !== lvl && k < lim) begin
         @(negedge clk);
         k++;
      end
      check("teach_active", 8'(lvl), 8'(teach_active));
   endtask
   task automatic scan_end(input int n, input int gap);
      i_cds_chain_model.scan(n, gap);
      wait_teach(1'b0, 8);
      repeat (3) @(negedge clk);
      check("fault_lamps_off", 8'h00, {6'h00, fault_lamp_red, fault_lamp_yellow});
      check("diag_after_teach", 8'h00, diag_gateway);
   endtask
   always @(negedge clk) begin
      if (host_ack === 1'b1) begin
         if (exp_q.size() == 0) check("host_ack_spurious", 8'h00, 8'h01);
         else check("host_data", exp_q.pop_front(), host_data);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      repeat (10) @(negedge clk);
      check("diag_reset", cds_pkg::DIAG_RESET, diag_gateway);
      check("power_boot", 8'h00, 8'(power_lamp_green));
      repeat (60) @(negedge clk);
      lamp_is("power_ready", 0, 1);
      lamp_is("function_unsaved", 1, 2);
      check("data_valid", 8'h01, 8'(chain_data_valid));
      host(cds_pkg::CMD_CATEGORY, 8'h05, cds_pkg::RESP_INVALID);
      host(8'h0C, 8'h01, cds_pkg::RESP_INVALID);
      for (int b = 0; b < 3; b++) begin
         errs = 3'(1 << b);
         repeat (3) @(negedge clk);
         check("diag_bit", 8'(1 << (b == 0 ? cds_pkg::BIT_INIT_ERR : b == 1 ?
            cds_pkg::BIT_SHORT : cds_pkg::BIT_COMM_ERR)), diag_gateway);
         if (b == 0) host(cds_pkg::CMD_CATEGORY, cds_pkg::NODE_GATEWAY, 8'h10);
         if (b == 1) lamp_is("fault_short", 3, 2);
         if (b == 2) check("data_valid", 8'h00, 8'(chain_data_valid));
      end
      errs = 3'h0;
      chain_if_fault = 1'b1;
      repeat (12) @(negedge clk);
      check("if_fault_early", 8'h00, diag_gateway);
      repeat (20) @(negedge clk);
      check("if_fault", 8'h01, diag_gateway);
      check("data_valid", 8'h00, 8'(chain_data_valid));
      chain_if_fault = 1'b0;
      chain_quality_poor = 1'b1;
      lamp_is("fault_poor", 2, 2);
      chain_quality_poor = 1'b0;
      for (int i = 1; i <= 3; i++) begin
         cats[i] = 8'($random(seed));
         i_cds_chain_model.cat_mem[i] = cats[i];
      end
      host(cds_pkg::CMD_TEACH, cds_pkg::NODE_GATEWAY, cds_pkg::TEACH_DONE_DATA);
      check("teach_host", 8'h01, 8'(teach_active));
      lamp_is("fault_teach", 2, 2);
      scan_end(3, 0);
      for (int i = 1; i <= 3; i++) host(cds_pkg::CMD_CATEGORY, 8'(i), cats[i]);
      host(cds_pkg::CMD_CATEGORY, 8'h20, cds_pkg::RESP_INVALID);
      i_cds_chain_model.cat_mem[2] = ~cats[2];
      i_cds_chain_model.scan(3, 2);
      repeat (4) @(negedge clk);
      check("diag_mismatch", 8'(1 << cds_pkg::BIT_TEACH_ERR), diag_gateway);
      lamp_is("fault_mismatch", 3, 1);
      lamp_is("function_mismatch", 1, 2);
      teach_button_n = 1'b0;
      repeat (12) @(negedge clk);
      teach_button_n = 1'b1;
      repeat (30) @(negedge clk);
      check("teach_short_press", 8'h00, 8'(teach_active));
      teach_button_n = 1'b0;
      wait_teach(1'b1, 80);
      teach_button_n = 1'b1;
      scan_end(3, 2);
      host(cds_pkg::CMD_CATEGORY, 8'h02, ~cats[2]);
      web_teach_req = 1'b1;
      wait_teach(1'b1, 10);
      web_teach_req = 1'b0;
      scan_end(3, 1);
      chain_present = 1'b0;
      lamp_is("function_no_chain", 1, 1);
      host(cds_pkg::CMD_TEACH, cds_pkg::NODE_GATEWAY, cds_pkg::TEACH_DONE_DATA);
      check("teach_no_chain", 8'h00, 8'(teach_active));
      supply_ok = 1'b0;
      // The supply pin passes the synchroniser before the lamp register sees it.
      repeat (8) @(negedge clk);
      lamp_is("power_off", 0, 0);
      test_done;
   end
endmodule
`default_nettype wire
